// ===== verilog/status_sel_pkg.sv
// Shared constants for the programmable status output selector
package status_sel_pkg;

	// Terminal counts: three transistor outputs then two relay outputs
	localparam int NUM_TERMS       = 5;
	localparam int NUM_TRANSISTOR  = 3;

	// Data widths
	localparam int CODE_W          = 11;
	localparam int VAL_W           = 16;

	// Register byte offsets on the APB slave
	localparam logic [7:0] OFS_CODE0     = 8'h00;
	localparam logic [7:0] OFS_CODE4     = 8'h10;
	localparam logic [7:0] OFS_FDT_LEVEL = 8'h14;
	localparam logic [7:0] OFS_CUR_WARN  = 8'h18;
	localparam logic [7:0] OFS_RESTART   = 8'h1C;
	localparam logic [7:0] OFS_HW_OC     = 8'h20;
	localparam logic [7:0] OFS_AUTO_DEC  = 8'h24;
	localparam logic [7:0] OFS_FLAGS     = 8'h28;
	localparam logic [7:0] OFS_TERMS     = 8'h2C;

	// Assignment codes (normal polarity); inverted codes add the offset
	localparam logic [10:0] CODE_INV_OFS = 11'h3E8;
	localparam logic [10:0] CODE_RUN     = 11'h000;
	localparam logic [10:0] CODE_FAR     = 11'h001;
	localparam logic [10:0] CODE_FDT     = 11'h002;
	localparam logic [10:0] CODE_UV      = 11'h003;
	localparam logic [10:0] CODE_IOL     = 11'h005;
	localparam logic [10:0] CODE_IPF     = 11'h006;
	localparam logic [10:0] CODE_OL      = 11'h007;
	localparam logic [10:0] CODE_RDY     = 11'h00A;
	localparam logic [10:0] CODE_LINE    = 11'h00B;
	localparam logic [10:0] CODE_INPUT   = 11'h00C;
	localparam logic [10:0] CODE_OUTPUT  = 11'h00D;
	localparam logic [10:0] CODE_AUX     = 11'h00F;
	localparam logic [10:0] CODE_M1_INV  = 11'h03C;
	localparam logic [10:0] CODE_ALARM   = 11'h063;

	// Bit positions in the flag vector
	localparam int FLG_RUN    = 0;
	localparam int FLG_FAR    = 1;
	localparam int FLG_FDT    = 2;
	localparam int FLG_UV     = 3;
	localparam int FLG_IOL    = 4;
	localparam int FLG_IPF    = 5;
	localparam int FLG_OL     = 6;
	localparam int FLG_RDY    = 7;
	localparam int FLG_LINE   = 8;
	localparam int FLG_INPUT  = 9;
	localparam int FLG_OUTPUT = 10;
	localparam int FLG_AUX    = 11;
	localparam int FLG_M1_INV = 12;
	localparam int FLG_ALARM  = 13;
	localparam int NUM_FLAGS  = 14;

	// Frequencies are in 0.1 Hz steps: 2.5 Hz tolerance, 1 Hz hysteresis
	localparam logic [15:0] FAR_TOL   = 16'h0019;
	localparam logic [15:0] FDT_HYST  = 16'h000A;

	// Restart modes that enable the restart flag
	localparam logic [2:0] RESTART_MIN = 3'h3;
	localparam logic [2:0] RESTART_MAX = 3'h5;

	// Setting values that enable the limiter sources
	localparam logic [1:0] HW_OC_ON     = 2'h1;
	localparam logic [1:0] AUTO_DEC_ON  = 2'h3;

	// Reset values
	localparam logic [10:0] CODE_RST  = 11'h000;
	localparam logic [15:0] LEVEL_RST = 16'h0000;
	localparam logic [2:0]  MODE_RST  = 3'h0;
	localparam logic [1:0]  SET_RST   = 2'h0;

	// Minimum limiting pulse: 100 ms at a 100 ns clock
	localparam int IOL_MIN_MS    = 100;
	localparam int CLK_PERIOD_NS = 100;
	localparam int IOL_MIN_CYC   = (IOL_MIN_MS * 1000000) / CLK_PERIOD_NS;

endpackage

// ===== verilog/min_pulse_stretch.sv
// Stretches a level so each assertion lasts a minimum number of cycles
`timescale 1ns/10ps
module min_pulse_stretch #(
	parameter int HOLD_CYC = 1000000
) (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic trig_in,
	output logic      pulse_out
);
	localparam int CW = $clog2(HOLD_CYC + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          pulse;
	} st_t;

	st_t st_r;
	st_t st_nxt;

	// Reload while the source is high, then run the hold time out
	always_comb begin
		st_nxt = st_r;
		if (trig_in) begin
			st_nxt.cnt   = CW'(HOLD_CYC - 1);
			st_nxt.pulse = 1'b1;
		end else if (st_r.cnt != '0) begin
			st_nxt.cnt   = st_r.cnt - CW'(1);
			st_nxt.pulse = 1'b1;
		end else begin
			st_nxt.pulse = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pulse_out = st_r.pulse;
endmodule // min_pulse_stretch

// ===== verilog/status_output_selector.sv
// Function
// - code selects a condition active high; code plus 1000 selects it inverted
// - contactor codes 11, 12, 13 have no inverted variant
// - 11 line contactor, 12 primary side contactor, 13 secondary side contactor
// - running above start, off below stop frequency, forced off during DC braking
// - arrival while output and reference differ by at most 2.5 Hz
// - detected above level, cleared below level minus 1 Hz
// - undervoltage below level, clears above it, held during undervoltage trip
// - run commands are blocked from run enable while undervoltage is flagged
// - limiting from software, hardware or auto decel; at least 100 ms long
// - restart flag during ride-through or from shutdown until reference reached
// - restart flag works only for restart modes 3, 4 or 5
// - overload warning above warning level; same level gives current detected
// - ready only after hardware preparation and with no protection active
// - switching sequence enabled only when 11, 12, 13 sit on transistor terminals
// - aux contactor on with run command, off once stopped after stop command
// - aux contactor drops at once on coast-to-stop or any alarm
// - after reset every terminal is normal polarity
`timescale 1ns/10ps
module status_output_selector #(
	parameter int IOL_HOLD_CYC = status_sel_pkg::IOL_MIN_CYC
) (
	input  wire logic        MCLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic [31:0]      PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic [15:0] OUT_FREQ_IN,
	input  wire logic [15:0] REF_FREQ_IN,
	input  wire logic [15:0] START_FREQ_IN,
	input  wire logic [15:0] STOP_FREQ_IN,
	input  wire logic        DC_BRAKE_IN,
	input  wire logic [15:0] DC_LINK_VOLT_IN,
	input  wire logic [15:0] UV_LEVEL_IN,
	input  wire logic        UV_TRIP_IN,
	input  wire logic        RUN_CMD_IN,
	input  wire logic        STOP_CMD_IN,
	input  wire logic        COAST_CMD_IN,
	input  wire logic        MOTOR_STOPPED_IN,
	input  wire logic        SW_CUR_LIMIT_IN,
	input  wire logic        HW_OC_LIMIT_IN,
	input  wire logic        AUTO_DECEL_IN,
	input  wire logic        PF_RIDE_THROUGH_IN,
	input  wire logic        UV_SHUTDOWN_IN,
	input  wire logic [15:0] OUT_CURRENT_IN,
	input  wire logic        HW_PREP_DONE_IN,
	input  wire logic        PROTECT_ACTIVE_IN,
	input  wire logic        ALARM_IN,
	input  wire logic        LINE_CONTACTOR_IN,
	input  wire logic        INPUT_CONTACTOR_IN,
	input  wire logic        OUTPUT_CONTACTOR_IN,
	input  wire logic        MOTOR1_INVERTER_DRIVEN_IN,
	output logic [4:0]       TERM_OUT,
	output logic             RUN_ENABLE_OUT,
	output logic             LINE_SWITCH_SEQ_EN_OUT,
	output logic             CURRENT_DETECTED_OUT
);
	localparam int NT = status_sel_pkg::NUM_TERMS;
	localparam int NF = status_sel_pkg::NUM_FLAGS;

	typedef struct packed {
		logic [NT-1:0][10:0] code;
		logic [15:0]         freq_detect_level_setting;
		logic [15:0]         current_warning_level_setting;
		logic [2:0]          restart_mode_setting;
		logic [1:0]          hw_overcurrent_limit_setting;
		logic [1:0]          auto_decel_setting;
		logic                run_flag;
		logic                freq_detected_flag;
		logic                undervoltage_flag;
		logic                power_fail_restart_flag;
		logic                aux_contactor_drive;
		logic [NT-1:0]       term;
		logic                run_en;
		logic                seq_en;
		logic [31:0]         prdata;
		logic                slverr;
	} st_t;

	st_t          st_r;
	st_t          st_nxt;
	logic [NF-1:0] flags;
	logic         limit_src;
	logic         output_limiting_flag;
	logic         freq_arrival_flag;
	logic         overload_warning_flag;
	logic         ready_flag;
	logic [15:0]  fdt_low;
	logic         wr_acc;
	logic         rd_setup;
	logic         restart_mode_ok;

	// Pick one flag by assignment code; inverted codes flip it
	function automatic logic sel_flag(input logic [10:0] code, input logic [NF-1:0] f);
		logic [10:0] base;
		logic        inv;
		logic        hit;
		logic        val;
		inv  = (code >= status_sel_pkg::CODE_INV_OFS);
		base = inv ? 11'(code - status_sel_pkg::CODE_INV_OFS) : code;
		hit  = 1'b1;
		val  = 1'b0;
		unique case (base)
			status_sel_pkg::CODE_RUN:    val = f[status_sel_pkg::FLG_RUN];
			status_sel_pkg::CODE_FAR:    val = f[status_sel_pkg::FLG_FAR];
			status_sel_pkg::CODE_FDT:    val = f[status_sel_pkg::FLG_FDT];
			status_sel_pkg::CODE_UV:     val = f[status_sel_pkg::FLG_UV];
			status_sel_pkg::CODE_IOL:    val = f[status_sel_pkg::FLG_IOL];
			status_sel_pkg::CODE_IPF:    val = f[status_sel_pkg::FLG_IPF];
			status_sel_pkg::CODE_OL:     val = f[status_sel_pkg::FLG_OL];
			status_sel_pkg::CODE_RDY:    val = f[status_sel_pkg::FLG_RDY];
			status_sel_pkg::CODE_LINE:   val = f[status_sel_pkg::FLG_LINE];
			status_sel_pkg::CODE_INPUT:  val = f[status_sel_pkg::FLG_INPUT];
			status_sel_pkg::CODE_OUTPUT: val = f[status_sel_pkg::FLG_OUTPUT];
			status_sel_pkg::CODE_AUX:    val = f[status_sel_pkg::FLG_AUX];
			status_sel_pkg::CODE_M1_INV: val = f[status_sel_pkg::FLG_M1_INV];
			status_sel_pkg::CODE_ALARM:  val = f[status_sel_pkg::FLG_ALARM];
			default:                     hit = 1'b0;
		endcase
		// Contactor drives refuse the inverted form outright
		if (inv && (base == status_sel_pkg::CODE_LINE || base == status_sel_pkg::CODE_INPUT ||
			base == status_sel_pkg::CODE_OUTPUT)) begin
			hit = 1'b0;
		end
		return hit ? (val ^ inv) : 1'b0;
	endfunction

	// Limiter sources; software always counts, hardware and auto decel each gated by its own enabling setting
	assign limit_src = SW_CUR_LIMIT_IN |
		(HW_OC_LIMIT_IN & (st_r.hw_overcurrent_limit_setting == status_sel_pkg::HW_OC_ON)) |
		(AUTO_DECEL_IN & (st_r.auto_decel_setting == status_sel_pkg::AUTO_DEC_ON));

	// Short limiter bursts would be missed by slow relays, so hold them
	min_pulse_stretch #(
		.HOLD_CYC (IOL_HOLD_CYC)
	) u_iol_stretch (
		.clk_in    (MCLK_IN),
		.reset_in  (RESET_IN),
		.trig_in   (limit_src),
		.pulse_out (output_limiting_flag)
	);

	// Level comparisons that need no memory
	assign freq_arrival_flag = ((OUT_FREQ_IN > REF_FREQ_IN) ? (OUT_FREQ_IN - REF_FREQ_IN) :
		(REF_FREQ_IN - OUT_FREQ_IN)) <= status_sel_pkg::FAR_TOL;
	assign overload_warning_flag = OUT_CURRENT_IN > st_r.current_warning_level_setting;
	assign ready_flag = HW_PREP_DONE_IN & ~PROTECT_ACTIVE_IN;
	assign fdt_low = (st_r.freq_detect_level_setting > status_sel_pkg::FDT_HYST) ?
		(st_r.freq_detect_level_setting - status_sel_pkg::FDT_HYST) : 16'h0000;
	assign restart_mode_ok = (st_r.restart_mode_setting >= status_sel_pkg::RESTART_MIN) &&
		(st_r.restart_mode_setting <= status_sel_pkg::RESTART_MAX);

	// Flag vector in the order of the flag positions
	always_comb begin
		flags = '0;
		flags[status_sel_pkg::FLG_RUN]    = st_r.run_flag;
		flags[status_sel_pkg::FLG_FAR]    = freq_arrival_flag;
		flags[status_sel_pkg::FLG_FDT]    = st_r.freq_detected_flag;
		flags[status_sel_pkg::FLG_UV]     = st_r.undervoltage_flag;
		flags[status_sel_pkg::FLG_IOL]    = output_limiting_flag;
		flags[status_sel_pkg::FLG_IPF]    = st_r.power_fail_restart_flag;
		flags[status_sel_pkg::FLG_OL]     = overload_warning_flag;
		flags[status_sel_pkg::FLG_RDY]    = ready_flag;
		flags[status_sel_pkg::FLG_LINE]   = LINE_CONTACTOR_IN;
		flags[status_sel_pkg::FLG_INPUT]  = INPUT_CONTACTOR_IN;
		flags[status_sel_pkg::FLG_OUTPUT] = OUTPUT_CONTACTOR_IN;
		flags[status_sel_pkg::FLG_AUX]    = st_r.aux_contactor_drive;
		flags[status_sel_pkg::FLG_M1_INV] = MOTOR1_INVERTER_DRIVEN_IN;
		flags[status_sel_pkg::FLG_ALARM]  = ALARM_IN;
	end

	// APB phases; the slave never waits, so writes land at the access edge
	assign wr_acc   = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign rd_setup = PSEL_IN & ~PENABLE_IN;

	// Next state: registers, sticky-free flags, terminal drive
	always_comb begin
		logic [7:0] widx;
		logic       has_line;
		logic       has_in;
		logic       has_out;
		st_nxt   = st_r;
		widx     = 8'h00;
		has_line = 1'b0;
		has_in   = 1'b0;
		has_out  = 1'b0;

		// Register writes; read-only words ignore writes
		if (wr_acc) begin
			if (PADDR_IN <= status_sel_pkg::OFS_CODE4 && PADDR_IN[1:0] == 2'b00) begin
				widx = PADDR_IN >> 2;
				st_nxt.code[widx[2:0]] = PWDATA_IN[10:0];
			end
			unique case (PADDR_IN)
				status_sel_pkg::OFS_FDT_LEVEL:
					st_nxt.freq_detect_level_setting = PWDATA_IN[15:0];
				status_sel_pkg::OFS_CUR_WARN:
					st_nxt.current_warning_level_setting = PWDATA_IN[15:0];
				status_sel_pkg::OFS_RESTART:
					st_nxt.restart_mode_setting = PWDATA_IN[2:0];
				status_sel_pkg::OFS_HW_OC:
					st_nxt.hw_overcurrent_limit_setting = PWDATA_IN[1:0];
				status_sel_pkg::OFS_AUTO_DEC:
					st_nxt.auto_decel_setting = PWDATA_IN[1:0];
				default: ;
			endcase
		end

		// Read data is prepared in the setup cycle so it leaves a flop
		if (rd_setup) begin
			st_nxt.prdata = 32'h0000_0000;
			st_nxt.slverr = 1'b0;
			if (PADDR_IN[1:0] != 2'b00) begin
				st_nxt.slverr = 1'b1;
			end else if (PADDR_IN <= status_sel_pkg::OFS_CODE4) begin
				widx = PADDR_IN >> 2;
				st_nxt.prdata[10:0] = st_r.code[widx[2:0]];
			end else begin
				unique case (PADDR_IN)
					status_sel_pkg::OFS_FDT_LEVEL:
						st_nxt.prdata[15:0] = st_r.freq_detect_level_setting;
					status_sel_pkg::OFS_CUR_WARN:
						st_nxt.prdata[15:0] = st_r.current_warning_level_setting;
					status_sel_pkg::OFS_RESTART:
						st_nxt.prdata[2:0] = st_r.restart_mode_setting;
					status_sel_pkg::OFS_HW_OC:
						st_nxt.prdata[1:0] = st_r.hw_overcurrent_limit_setting;
					status_sel_pkg::OFS_AUTO_DEC:
						st_nxt.prdata[1:0] = st_r.auto_decel_setting;
					status_sel_pkg::OFS_FLAGS:
						st_nxt.prdata[NF-1:0] = flags;
					status_sel_pkg::OFS_TERMS:
						st_nxt.prdata[NT-1:0] = st_r.term;
					default:
						st_nxt.slverr = 1'b1;
				endcase
			end
		end

		// Running flag with start/stop hysteresis; braking overrides
		if (DC_BRAKE_IN) begin
			st_nxt.run_flag = 1'b0;
		end else if (OUT_FREQ_IN > START_FREQ_IN) begin
			st_nxt.run_flag = 1'b1;
		end else if (OUT_FREQ_IN < STOP_FREQ_IN) begin
			st_nxt.run_flag = 1'b0;
		end

		// Frequency detection with fixed hysteresis band
		if (OUT_FREQ_IN > st_r.freq_detect_level_setting) begin
			st_nxt.freq_detected_flag = 1'b1;
		end else if (OUT_FREQ_IN < fdt_low) begin
			st_nxt.freq_detected_flag = 1'b0;
		end

		// Undervoltage; a trip keeps it up even after the bus recovers
		if (DC_LINK_VOLT_IN < UV_LEVEL_IN || UV_TRIP_IN) begin
			st_nxt.undervoltage_flag = 1'b1;
		end else if (DC_LINK_VOLT_IN > UV_LEVEL_IN) begin
			st_nxt.undervoltage_flag = 1'b0;
		end

		// Run commands pass only with no undervoltage present or pending
		st_nxt.run_en = RUN_CMD_IN & ~st_r.undervoltage_flag & ~st_nxt.undervoltage_flag;

		// Restart flag; reaching the reference ends the shutdown window
		if (!restart_mode_ok) begin
			st_nxt.power_fail_restart_flag = 1'b0;
		end else if (PF_RIDE_THROUGH_IN || UV_SHUTDOWN_IN) begin
			st_nxt.power_fail_restart_flag = 1'b1;
		end else if (OUT_FREQ_IN >= REF_FREQ_IN) begin
			st_nxt.power_fail_restart_flag = 1'b0;
		end

		// Aux contactor; coast and alarm beat a run command in the same cycle
		if (COAST_CMD_IN || ALARM_IN) begin
			st_nxt.aux_contactor_drive = 1'b0;
		end else if (RUN_CMD_IN) begin
			st_nxt.aux_contactor_drive = 1'b1;
		end else if (STOP_CMD_IN && MOTOR_STOPPED_IN) begin
			st_nxt.aux_contactor_drive = 1'b0;
		end

		// Each terminal reads only its own code, so a rewrite touches no other
		for (int t = 0; t < NT; t++) begin
			st_nxt.term[t] = sel_flag(st_r.code[t], flags);
		end

		// Sequence needs all three drives on the transistor terminals
		for (int t = 0; t < status_sel_pkg::NUM_TRANSISTOR; t++) begin
			has_line = has_line | (st_r.code[t] == status_sel_pkg::CODE_LINE);
			has_in   = has_in   | (st_r.code[t] == status_sel_pkg::CODE_INPUT);
			has_out  = has_out  | (st_r.code[t] == status_sel_pkg::CODE_OUTPUT);
		end
		st_nxt.seq_en = has_line & has_in & has_out;
	end

	// State register; codes come up in normal polarity
	always_ff @(posedge MCLK_IN) begin
		if (RESET_IN) begin
			st_r <= '0;
			for (int t = 0; t < NT; t++) begin
				st_r.code[t] <= status_sel_pkg::CODE_RST;
			end
			st_r.freq_detect_level_setting     <= status_sel_pkg::LEVEL_RST;
			st_r.current_warning_level_setting <= status_sel_pkg::LEVEL_RST;
			st_r.restart_mode_setting          <= status_sel_pkg::MODE_RST;
			st_r.hw_overcurrent_limit_setting  <= status_sel_pkg::SET_RST;
			st_r.auto_decel_setting            <= status_sel_pkg::SET_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign PRDATA_OUT             = st_r.prdata;
	assign PSLVERR_OUT            = st_r.slverr & PSEL_IN & PENABLE_IN;
	assign PREADY_OUT             = 1'b1;
	assign TERM_OUT               = st_r.term;
	assign RUN_ENABLE_OUT         = st_r.run_en;
	assign LINE_SWITCH_SEQ_EN_OUT = st_r.seq_en;
	assign CURRENT_DETECTED_OUT   = overload_warning_flag;

	// Checks on terminal 0, the flags, run enable and sequence enable
	sequence s_code0(logic [10:0] c);
		st_r.code[0] == c;
	endsequence

	property p_pol_inv;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		s_code0(11'h424) |=> TERM_OUT[0] == !$past(MOTOR1_INVERTER_DRIVEN_IN);
	endproperty
	a_pol_inv: assert property (p_pol_inv) else $error("inverted code not inverted");

	property p_no_inv_contactor;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		s_code0(11'h3F3) ##1 s_code0(11'h3F3) |-> !TERM_OUT[0];
	endproperty
	a_no_inv_contactor: assert property (p_no_inv_contactor)
		else $error("inverted contactor code drove terminal");

	property p_contactor_map;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		s_code0(11'h00C) |=> TERM_OUT[0] == $past(INPUT_CONTACTOR_IN);
	endproperty
	a_contactor_map: assert property (p_contactor_map) else $error("code 12 mismapped");

	property p_run_brake;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		DC_BRAKE_IN |=> (!st_r.run_flag and (s_code0(11'h000) |=> !TERM_OUT[0]));
	endproperty
	a_run_brake: assert property (p_run_brake) else $error("running during braking");

	property p_fdt_hold;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		st_r.freq_detected_flag && OUT_FREQ_IN >= fdt_low |=> st_r.freq_detected_flag;
	endproperty
	a_fdt_hold: assert property (p_fdt_hold) else $error("detect dropped inside band");

	property p_uv_run;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		st_r.undervoltage_flag |-> !RUN_ENABLE_OUT;
	endproperty
	a_uv_run: assert property (p_uv_run) else $error("run passed in undervoltage");

	property p_iol_min;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		$rose(output_limiting_flag) |-> output_limiting_flag [*8];
	endproperty
	a_iol_min: assert property (p_iol_min) else $error("limiting pulse too short");

	property p_ipf_mode;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		!restart_mode_ok |=> !st_r.power_fail_restart_flag;
	endproperty
	a_ipf_mode: assert property (p_ipf_mode) else $error("restart flag in wrong mode");

	property p_aux_kill;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		(COAST_CMD_IN || ALARM_IN) |=> !st_r.aux_contactor_drive;
	endproperty
	a_aux_kill: assert property (p_aux_kill) else $error("aux stayed on");

	property p_unmatched;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		s_code0(11'h1F4) |=> !TERM_OUT[0];
	endproperty
	a_unmatched: assert property (p_unmatched) else $error("unlisted code active");

	property p_seq_en;
		@(posedge MCLK_IN) disable iff (RESET_IN)
		LINE_SWITCH_SEQ_EN_OUT |-> ($past(st_r.code[0]) == 11'h00B ||
			$past(st_r.code[1]) == 11'h00B || $past(st_r.code[2]) == 11'h00B);
	endproperty
	a_seq_en: assert property (p_seq_en) else $error("sequence enabled without drive");
endmodule // status_output_selector

// ===== dv/term_observer.sv
// Model of the equipment wired to the output terminals
`timescale 1ns/10ps
module term_observer #(
	parameter int MASK_CYC = 30
) (
	input  wire logic       clk_in,
	input  wire logic [4:0] term_in,
	output logic [4:0]      seen_out
);
	int cnt = 0;
	// Ignore the terminals until they can be trusted after power-up
	always @(posedge clk_in) begin
		if (cnt < MASK_CYC) begin
			cnt <= cnt + 1;
		end
		seen_out <= (cnt < MASK_CYC) ? 5'h00 : term_in;
	end
endmodule // term_observer

// ===== dv/tb.sv
// Self-checking testbench for the status output selector
`timescale 1ns/10ps
module tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  padr = 8'h00;
	logic [31:0] pwd = 32'h00000000;
	logic [31:0] prd, rd;
	logic        pready, perr, er, run_en, seq_en, cdet;
	logic [17:0] b = 18'h00800;
	logic [15:0] ofr = 16'h01F4;
	logic [15:0] rfr = 16'h020D;
	logic [15:0] vlt = 16'h0200;
	logic [15:0] cur = 16'h0000;
	logic [4:0]  term, seen;
	int          n_errors = 0;
	int          samples_checked = 0;

	// Free-running control clock
	always #50 clk = ~clk;

	// Single-bit status inputs come from the vector b to keep the bench short
	status_output_selector #(.IOL_HOLD_CYC(16)) dut_u (.MCLK_IN(clk), .RESET_IN(rst),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr),
		.PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
		.OUT_FREQ_IN(ofr), .REF_FREQ_IN(rfr), .START_FREQ_IN(16'h000A),
		.STOP_FREQ_IN(16'h0005), .DC_BRAKE_IN(b[0]), .DC_LINK_VOLT_IN(vlt),
		.UV_LEVEL_IN(16'h0100), .UV_TRIP_IN(b[1]), .RUN_CMD_IN(b[2]), .STOP_CMD_IN(b[3]),
		.COAST_CMD_IN(b[4]), .MOTOR_STOPPED_IN(b[5]), .SW_CUR_LIMIT_IN(b[6]),
		.HW_OC_LIMIT_IN(b[7]), .AUTO_DECEL_IN(b[8]), .PF_RIDE_THROUGH_IN(b[9]),
		.UV_SHUTDOWN_IN(b[10]), .OUT_CURRENT_IN(cur), .HW_PREP_DONE_IN(b[11]),
		.PROTECT_ACTIVE_IN(b[12]), .ALARM_IN(b[13]), .LINE_CONTACTOR_IN(b[14]),
		.INPUT_CONTACTOR_IN(b[15]), .OUTPUT_CONTACTOR_IN(b[16]),
		.MOTOR1_INVERTER_DRIVEN_IN(b[17]), .TERM_OUT(term), .RUN_ENABLE_OUT(run_en),
		.LINE_SWITCH_SEQ_EN_OUT(seq_en), .CURRENT_DETECTED_OUT(cdet));

	term_observer #(.MASK_CYC(30)) obs_u (.clk_in(clk), .term_in(term), .seen_out(seen));

	task summarize();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	// One APB transfer; the request holds until pready is seen high, giving up after 20 cycles
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			summarize();
		end
	endtask

	task wcode(input int t, input logic [10:0] c);
		apb(1'b1, 8'(t * 4), {21'h000000, c});
	endtask

	// Let flags and the terminal register settle before sampling
	task tchk(input int t, input logic e, input int w = 4);
		repeat (w) @(posedge clk);
		chk("terminal", {31'h00000000, e}, {31'h00000000, term[t]});
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 8'h00, 32'h00000000);
		chk("code0", 32'h00000000, rd);
		b[17] <= 1'b1;
		wcode(0, 11'h03C);
		tchk(0, 1'b1);
		wcode(0, 11'h424);
		tchk(0, 1'b0);
		wcode(1, 11'h03C);
		tchk(0, 1'b0);
		for (int i = 0; i < 3; i++) begin
			b[14 + i] <= 1'b1;
			wcode(0, 11'h00B + 11'(i));
			tchk(0, 1'b1);
			// Drive low so an inverted form would show high
			b[14 + i] <= 1'b0;
			wcode(0, 11'h3F3 + 11'(i));
			tchk(0, 1'b0);
		end
		wcode(0, 11'h00B);
		wcode(1, 11'h00C);
		wcode(2, 11'h00D);
		tchk(2, 1'b0);
		chk("seq_en", 32'h1, {31'h0, seq_en});
		b[17] <= 1'b1;
		wcode(0, 11'h1F4);
		tchk(0, 1'b0);
		wcode(1, 11'h3EC);
		tchk(1, 1'b0);
		chk("seq_en", 32'h0, {31'h0, seq_en});
		wcode(0, 11'h001);
		tchk(0, 1'b1);
		rfr <= 16'h020E;
		tchk(0, 1'b0);
		wcode(0, 11'h000);
		tchk(0, 1'b1);
		b[0] <= 1'b1;
		tchk(0, 1'b0);
		b[0] <= 1'b0;
		apb(1'b1, 8'h14, 32'h000001F4);
		wcode(0, 11'h002);
		ofr <= 16'h01E9;
		tchk(0, 1'b0);
		ofr <= 16'h01F5;
		tchk(0, 1'b1);
		ofr <= 16'h01EB;
		tchk(0, 1'b1);
		ofr <= 16'h01E9;
		tchk(0, 1'b0);
		wcode(1, 11'h003);
		vlt <= 16'h00FF;
		b[2] <= 1'b1;
		tchk(1, 1'b1);
		chk("run_en", 32'h0, {31'h0, run_en});
		vlt <= 16'h0101;
		tchk(1, 1'b0);
		chk("run_en", 32'h1, {31'h0, run_en});
		b[1] <= 1'b1;
		tchk(1, 1'b1);
		b[1] <= 1'b0;
		wcode(0, 11'h00F);
		tchk(0, 1'b1);
		b[4] <= 1'b1;
		tchk(0, 1'b0);
		b[4] <= 1'b0;
		tchk(0, 1'b1);
		b[13] <= 1'b1;
		tchk(0, 1'b0);
		b[13] <= 1'b0;
		tchk(0, 1'b1);
		b[2] <= 1'b0;
		b[3] <= 1'b1;
		tchk(0, 1'b1);
		b[5] <= 1'b1;
		tchk(0, 1'b0);
		wcode(3, 11'h005);
		b[6] <= 1'b1;
		@(posedge clk);
		b[6] <= 1'b0;
		tchk(3, 1'b1, 3);
		tchk(3, 1'b1, 14);
		tchk(3, 1'b0, 1);
		// Hardware limiter counts only once its setting enables it
		b[7] <= 1'b1;
		tchk(3, 1'b0);
		apb(1'b1, 8'h20, 32'h00000001);
		tchk(3, 1'b1);
		b[7] <= 1'b0;
		tchk(3, 1'b0, 20);
		wcode(0, 11'h006);
		apb(1'b1, 8'h1C, 32'h00000002);
		b[9] <= 1'b1;
		tchk(0, 1'b0);
		apb(1'b1, 8'h1C, 32'h00000003);
		tchk(0, 1'b1);
		b[9] <= 1'b0;
		ofr <= 16'h020E;
		tchk(0, 1'b0);
		wcode(0, 11'h00A);
		tchk(0, 1'b1);
		b[12] <= 1'b1;
		tchk(0, 1'b0);
		wcode(4, 11'h007);
		apb(1'b1, 8'h18, 32'h00000100);
		cur <= 16'h0101;
		tchk(4, 1'b1);
		chk("current_detected", 32'h1, {31'h0, cdet});
		cur <= 16'h0100;
		tchk(4, 1'b0);
		chk("current_detected", 32'h0, {31'h0, cdet});
		chk("seen", {27'h0, term}, {27'h0, seen});
		apb(1'b0, 8'h40, 32'h00000000);
		chk("slverr", 32'h1, {31'h0, er});
		summarize();
	end
endmodule // tb
